// >>> logic/counter_array_ccm.sv
// The implementer's own choice: the AHB-Lite slave port.
`default_nettype none
module counter_array_ccm #(
  parameter int NUM_MODULES = 3
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  // capture/compare pins
  input  wire logic [NUM_MODULES-1:0] module_io_pin_in,
  output logic      [NUM_MODULES-1:0] module_io_pin_out,
  output logic      [NUM_MODULES-1:0] module_io_pin_oe_n,
  // interrupt
  output logic                        irq
);

  // addresses are fixed per module, so no more than three fit
  if (NUM_MODULES < 1 || NUM_MODULES > 3) begin : g_bad_count
    $error("NUM_MODULES must be 1 to 3");
  end

  // bus, counter and module state
  cca_pkg::bus_state_e bus_state;
  cca_pkg::mode_s      mode [NUM_MODULES];
  logic [15:0]         value [NUM_MODULES];
  logic [15:0]         counter;
  logic [3:0]          status;
  logic [3:0]          irq_enable;
  logic                run;
  logic                wr_go;
  logic                idx_ok;
  logic [7:0]          idx;
  // pin path: two sync stages, then the edge reference
  logic [NUM_MODULES-1:0] pin_meta;
  logic [NUM_MODULES-1:0] pin_sync;
  logic [NUM_MODULES-1:0] pin_prev;
  logic [NUM_MODULES-1:0] flag_set;
  logic [7:0]          rd_part [NUM_MODULES+1];

  // register index compare, shared by the write and read decoders
  function automatic logic idx_is(input logic [7:0] cur,
                                  input logic [7:0] target);
    return cur == target;
  endfunction

  // module flags sit below the overflow flag in the status byte
  if (cca_pkg::OVERFLOW_BIT < NUM_MODULES ||
      cca_pkg::OVERFLOW_BIT >= cca_pkg::STATUS_WIDTH) begin : g_bad_layout
    $error("status layout cannot hold the module flags");
  end

  // address phase decode
  wire logic       take     = hsel & hready & htrans[1];
  wire logic       addr_ok  = (haddr[1:0] == 2'b00) &
                              (haddr[31:cca_pkg::IDX_MSB+1] == '0) &
                              (hsize == cca_pkg::HSIZE_WORD);
  wire logic       rd_start = take & ~hwrite;
  wire logic       wr_start = take & hwrite & addr_ok;
  wire logic [7:0] wbyte    = hwdata[7:0];

  // one select per common register, shared by the write and read paths
  wire logic       hit_cl   = idx_is(idx, cca_pkg::COUNTER_LOW_IDX);
  wire logic       hit_ch   = idx_is(idx, cca_pkg::COUNTER_HIGH_IDX);
  wire logic       hit_stat = idx_is(idx, cca_pkg::STATUS_IDX);
  wire logic       hit_ien  = idx_is(idx, cca_pkg::IRQ_ENABLE_IDX);
  wire logic       hit_ctrl = idx_is(idx, cca_pkg::CONTROL_IDX);
  wire logic       wr_cl    = wr_go & hit_cl;
  wire logic       wr_ch    = wr_go & hit_ch;
  wire logic       wr_stat  = wr_go & hit_stat;
  wire logic       wr_ien   = wr_go & hit_ien;
  wire logic       wr_ctrl  = wr_go & hit_ctrl;

  // common registers on the read side; modules add theirs below
  wire logic [7:0] rd_common =
    ({8{hit_cl}} & counter[7:0]) |
    ({8{hit_ch}} & counter[15:8]) |
    ({8{hit_stat}} & {4'h0, status}) |
    ({8{hit_ien}} & {4'h0, irq_enable}) |
    ({8{hit_ctrl}} & {7'h00, run});
  assign rd_part[0] = rd_common;
  // unmapped or refused addresses read as zero
  wire logic [7:0] rd_byte = idx_ok ? rd_part[NUM_MODULES] : 8'h00;

  // bus slave: writes complete with no wait, reads take one wait state
  // so a read right after a write sees the written value
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_state <= cca_pkg::BUS_IDLE;
      wr_go     <= 1'b0;
      idx       <= 8'h00;
      idx_ok    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= cca_pkg::HRESP_OKAY;
    end else begin
      wr_go <= wr_start;
      hresp <= cca_pkg::HRESP_OKAY;
      if (take) begin
        idx    <= haddr[cca_pkg::IDX_MSB:cca_pkg::IDX_LSB];
        idx_ok <= addr_ok;
      end
      // only reads leave idle; writes finish in their first data cycle
      case (bus_state)
        cca_pkg::BUS_IDLE: begin
          if (rd_start) begin
            bus_state <= cca_pkg::BUS_READ;
            hreadyout <= 1'b0;
          end
        end
        cca_pkg::BUS_READ: begin
          bus_state <= cca_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= {24'h00_0000, rd_byte};
        end
        default: begin
          bus_state <= cca_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // counter next value; a software write wins over counting
  // no snapshot of the high byte: reading both halves while running
  // may see a carry land between the two reads
  wire logic        cnt_wrap = run & (counter == cca_pkg::COUNTER_TOP) &
                               ~wr_cl & ~wr_ch;
  wire logic [15:0] next_counter =
    wr_cl ? {counter[15:8], wbyte} :
    wr_ch ? {wbyte, counter[7:0]} :
    run   ? counter + 16'h0001 : counter;

  // counter and run flag; run only changes from the bus
  always_ff @(posedge clock) begin
    if (reset) begin
      counter <= cca_pkg::COUNTER_RESET;
      run     <= 1'b0;
    end else begin
      counter <= next_counter;
      if (wr_ctrl) begin
        run <= wbyte[cca_pkg::RUN_BIT];
      end
    end
  end

  // pin synchroniser; only pin_sync feeds the edge detector
  // pin_meta may be metastable, so nothing but pin_sync reads it
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= module_io_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // per-module capture/compare logic
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
    // register selects and write strobes of this module
    wire logic hit_mode  = idx_is(idx, cca_pkg::MODE_IDX[m]);
    wire logic hit_vlow  = idx_is(idx, cca_pkg::VLOW_IDX[m]);
    wire logic hit_vhigh = idx_is(idx, cca_pkg::VHIGH_IDX[m]);
    wire logic wr_mode   = wr_go & hit_mode;
    wire logic wr_vlow   = wr_go & hit_vlow;
    wire logic wr_vhigh  = wr_go & hit_vhigh;

    cca_pkg::mode_s md;
    assign md = mode[m];
    // frequency output compares the low byte only and steps it
    wire logic freq  = md.match_toggle_enable & md.pulse_width_enable;
    wire logic pwm   = md.pulse_width_enable & ~md.match_toggle_enable;
    wire logic m_low = counter[7:0] == value[m][7:0];
    wire logic m_all = counter == value[m];
    wire logic match = md.comparator_enable & run &
                       (freq ? m_low : m_all);
    // edges of the synchronised pin; one cycle each
    wire logic rise  = pin_sync[m] & ~pin_prev[m];
    wire logic fall  = ~pin_sync[m] & pin_prev[m];
    wire logic cap_rise = rise & md.rising_capture_enable;
    wire logic cap_fall = fall & md.falling_capture_enable;
    wire logic capture  = cap_rise | cap_fall;
    wire logic tog_hit  = match & md.match_toggle_enable;

    // pulse width: high once the counter reaches the compare value
    wire logic pwm_level = md.wide_pulse_select ?
                           (counter >= value[m]) :
                           (counter[7:0] >= value[m][7:0]);
    wire logic drive = md.comparator_enable &
                       (md.match_toggle_enable | md.pulse_width_enable);

    // flag sources and this module's share of the read mux
    assign flag_set[m] = capture |
                         (match & md.match_flag_enable);
    assign rd_part[m+1] = rd_part[m] |
                          ({8{hit_mode}} & md) |
                          ({8{hit_vlow}} & value[m][7:0]) |
                          ({8{hit_vhigh}} & value[m][15:8]);

    // mode byte
    always_ff @(posedge clock) begin
      if (reset) begin
        mode[m] <= cca_pkg::MODE_RESET;
      end else if (wr_mode) begin
        mode[m] <= wbyte;
      end
    end

    // value: a capture beats a software write in the same cycle
    // frequency mode steps the next match point by the high byte
    always_ff @(posedge clock) begin
      if (reset) begin
        value[m] <= cca_pkg::VALUE_RESET;
      end else if (capture) begin
        value[m] <= counter;
      end else if (freq && match) begin
        value[m][7:0] <= value[m][7:0] + value[m][15:8];
      end else if (wr_vlow) begin
        value[m][7:0] <= wbyte;
      end else if (wr_vhigh) begin
        value[m][15:8] <= wbyte;
      end
    end

    // pin driver; enable is low while the pin is driven
    // pwm level lags the counter by one cycle through this flop
    always_ff @(posedge clock) begin
      if (reset) begin
        module_io_pin_out[m]  <= 1'b0;
        module_io_pin_oe_n[m] <= 1'b1;
      end else begin
        module_io_pin_oe_n[m] <= ~drive;
        if (md.comparator_enable && pwm) begin
          module_io_pin_out[m] <= pwm_level;
        end else if (tog_hit) begin
          module_io_pin_out[m] <= ~module_io_pin_out[m];
        end
      end
    end
  end

  // sticky status; an event in the clearing cycle survives the clear
  logic [3:0] set_vec;
  logic [3:0] flag_mask;
  always_comb begin
    set_vec   = '0;
    flag_mask = '0;
    set_vec[cca_pkg::OVERFLOW_BIT]   = cnt_wrap;
    flag_mask[cca_pkg::OVERFLOW_BIT] = 1'b1;
    for (int i = 0; i < NUM_MODULES; i++) begin
      set_vec[i]   = flag_set[i];
      flag_mask[i] = mode[i].module_flag_irq_mask;
    end
  end
  wire logic [3:0] w1c         = wr_stat ? wbyte[3:0] : 4'h0;
  wire logic [3:0] next_status = (status & ~w1c) | set_vec;
  // irq looks at next_status so it rises with the flag, not after it
  wire logic [3:0] next_irq    = next_status & irq_enable & flag_mask;

  // status, enable and registered interrupt
  always_ff @(posedge clock) begin
    if (reset) begin
      status     <= cca_pkg::STATUS_RESET;
      irq_enable <= cca_pkg::IRQ_ENABLE_RESET;
      irq        <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_ien) begin
        irq_enable <= wbyte[3:0];
      end
      irq <= |next_irq;
    end
  end

endmodule
`default_nettype wire

// >>> shared/cca_pkg.sv
`default_nettype none
package cca_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] MODE_IDX [3] = '{8'hda, 8'hdb, 8'hdc};
  localparam logic [7:0] VLOW_IDX [3] = '{8'hfb, 8'he9, 8'heb};
  localparam logic [7:0] VHIGH_IDX [3] = '{8'hfc, 8'hea, 8'hec};
  localparam logic [7:0] COUNTER_LOW_IDX = 8'hf9;
  localparam logic [7:0] COUNTER_HIGH_IDX = 8'hfa;
  localparam logic [7:0] STATUS_IDX = 8'hd0;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'hd1;
  localparam logic [7:0] CONTROL_IDX = 8'hd2;

  // field positions and reset values
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;
  localparam int unsigned STATUS_WIDTH = 4;
  localparam int unsigned OVERFLOW_BIT = 3;
  localparam int unsigned RUN_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
  localparam logic [15:0] COUNTER_TOP = 16'hffff;

  // ahb-lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // one module's mode byte, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic match_toggle_enable;
    logic pulse_width_enable;
    logic module_flag_irq_mask;
  } mode_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_e;
endpackage
`default_nettype wire

// >>> tb/cca_checker_sva.sv
`default_nettype none
module cca_checker #(
  parameter int NUM_MODULES = 3
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic [31:0]            hrdata,
  input wire logic                   hresp,
  // pins and interrupt
  input wire logic [NUM_MODULES-1:0] module_io_pin_in,
  input wire logic [NUM_MODULES-1:0] module_io_pin_out,
  input wire logic [NUM_MODULES-1:0] module_io_pin_oe_n,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_dp;
  wire  taken = hsel & hready & htrans[1];
  // write data phases are the only cause of a mode change
  always_ff @(posedge clock) begin
    if (reset) wr_dp <= 1'b0;
    else       wr_dp <= taken & hwrite;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  AST_RD_WAIT: assert property (taken && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_WR_NOWAIT: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_READY_ONE: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  AST_HRDATA_UP: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_HRDATA_HOLD: assert property (!$rose(hreadyout) |->
    $stable(hrdata)) else $error("hrdata moved");
  AST_OE_CAUSE: assert property ($changed(module_io_pin_oe_n) |->
    $past(wr_dp) || $past(wr_dp, 2)) else $error("oe moved alone");
  AST_RST_OUT: assert property ($fell(reset) |-> hreadyout && !irq &&
    &module_io_pin_oe_n && hrdata == 32'h0000_0000 && !module_io_pin_out)
    else $error("outputs not at reset values");
endmodule
bind counter_array_ccm cca_checker #(.NUM_MODULES(NUM_MODULES)) chk_u (
  .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
  .module_io_pin_oe_n(module_io_pin_oe_n), .irq(irq));
`default_nettype wire

// >>> tb/pin_source_model.sv
`default_nettype none
module pin_source_model #(
  parameter int N = 3
) (
  // far side request and block drive
  input  wire logic [N-1:0] drive_req,
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe_n,
  // resolved wire level
  output logic      [N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // far side drives only where the block has let go of the pin
  assign pin_level = (pin_oe_n & drive_req) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = cca_pkg::HSIZE_WORD;
  logic [2:0]  req = 3'b000;
  logic        hreadyout, hresp, irq;
  logic [31:0] hrdata, rd;
  logic [2:0]  pin_in, pin_out, pin_oe_n;
  wire         hready = hreadyout;
  int          err_total = 0;
  int          checked = 0;
  int          n;
  logic        prev;
  localparam logic [7:0] R_IDX [9] = '{cca_pkg::MODE_IDX[0],
    cca_pkg::MODE_IDX[1], cca_pkg::MODE_IDX[2], cca_pkg::VLOW_IDX[0],
    cca_pkg::VLOW_IDX[1], cca_pkg::VLOW_IDX[2], cca_pkg::COUNTER_LOW_IDX,
    cca_pkg::VHIGH_IDX[0], 8'h10};
  localparam logic [7:0] R_WD [9] = '{8'ha5, 8'h4a, 8'hc6, 8'h3c, 8'hc3,
    8'h81, 8'h7e, 8'h99, 8'h55};
  localparam logic [7:0] R_EX [9] = '{8'ha5, 8'h4a, 8'hc6, 8'h3c, 8'hc3,
    8'h81, 8'h7e, 8'h99, 8'h00};

  always #2 clock = ~clock;

  counter_array_ccm dut_u (.clock(clock), .reset(reset), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .module_io_pin_in(pin_in),
    .module_io_pin_out(pin_out), .module_io_pin_oe_n(pin_oe_n), .irq(irq));
  pin_source_model ext_u (.drive_req(req), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_level(pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic [7:0] idx, input logic w,
                      input logic [7:0] wd);
    @(posedge clock);
    htrans <= 2'b10;
    haddr <= {22'h00_0000, idx, 2'b00};
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask

  // high cycles of pin 2 over one full 8-bit period
  task automatic pwm_count();
    n = 0;
    repeat (256) begin
      @(posedge clock);
      if (pin_out[2] === 1'b1) n++;
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #80000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) rchk(cca_pkg::MODE_IDX[i], 8'h00);
    for (int i = 0; i < 9; i++) begin
      xfer(R_IDX[i], 1'b1, R_WD[i]);
      rchk(R_IDX[i], R_EX[i]);
    end
    // rising capture with the flag interrupt unmasked
    xfer(cca_pkg::STATUS_IDX, 1'b1, 8'h0f);
    xfer(cca_pkg::COUNTER_LOW_IDX, 1'b1, 8'h37);
    xfer(cca_pkg::COUNTER_HIGH_IDX, 1'b1, 8'h12);
    xfer(cca_pkg::IRQ_ENABLE_IDX, 1'b1, 8'h01);
    xfer(cca_pkg::MODE_IDX[0], 1'b1, 8'h21);
    req[0] <= 1'b1;
    repeat (8) @(posedge clock);
    rchk(cca_pkg::VLOW_IDX[0], 8'h37);
    rchk(cca_pkg::VHIGH_IDX[0], 8'h12);
    rchk(cca_pkg::STATUS_IDX, 8'h01);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    xfer(cca_pkg::STATUS_IDX, 1'b1, 8'h01);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // falling capture, flag masked from the interrupt
    xfer(cca_pkg::MODE_IDX[0], 1'b1, 8'h10);
    xfer(cca_pkg::COUNTER_LOW_IDX, 1'b1, 8'h44);
    req[0] <= 1'b0;
    repeat (8) @(posedge clock);
    rchk(cca_pkg::VLOW_IDX[0], 8'h44);
    rchk(cca_pkg::STATUS_IDX, 8'h01);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // match toggle on module 1, 8-bit then 16-bit pulse width on module 2
    xfer(cca_pkg::STATUS_IDX, 1'b1, 8'h0f);
    xfer(cca_pkg::MODE_IDX[1], 1'b1, 8'h4c);
    xfer(cca_pkg::VLOW_IDX[1], 1'b1, 8'h10);
    xfer(cca_pkg::VHIGH_IDX[1], 1'b1, 8'h00);
    xfer(cca_pkg::MODE_IDX[2], 1'b1, 8'h42);
    xfer(cca_pkg::VLOW_IDX[2], 1'b1, 8'h80);
    xfer(cca_pkg::VHIGH_IDX[2], 1'b1, 8'h00);
    xfer(cca_pkg::COUNTER_LOW_IDX, 1'b1, 8'h00);
    xfer(cca_pkg::COUNTER_HIGH_IDX, 1'b1, 8'h00);
    xfer(cca_pkg::CONTROL_IDX, 1'b1, 8'h01);
    repeat (8) @(posedge clock);
    pwm_count();
    chk(n, 32'h0000_0080);
    chk({30'h0000_0000, pin_oe_n[1], pin_out[1]}, 32'h0000_0001);
    rchk(cca_pkg::STATUS_IDX, 8'h02);
    xfer(cca_pkg::VHIGH_IDX[2], 1'b1, 8'hff);
    xfer(cca_pkg::MODE_IDX[2], 1'b1, 8'hc2);
    repeat (4) @(posedge clock);
    pwm_count();
    chk(n, 32'h0000_0000);
    // frequency output on module 2: a toggle every 0x20 counts
    xfer(cca_pkg::VLOW_IDX[2], 1'b1, 8'h10);
    xfer(cca_pkg::VHIGH_IDX[2], 1'b1, 8'h20);
    xfer(cca_pkg::MODE_IDX[2], 1'b1, 8'h46);
    repeat (256) @(posedge clock);
    n = 0;
    prev = pin_out[2];
    repeat (256) begin
      @(posedge clock);
      if (pin_out[2] !== prev) n++;
      prev = pin_out[2];
    end
    chk(n, 32'h0000_0008);
    // counter wrap sets overflow, then module 1 matches again
    xfer(cca_pkg::COUNTER_LOW_IDX, 1'b1, 8'h00);
    xfer(cca_pkg::COUNTER_HIGH_IDX, 1'b1, 8'hff);
    xfer(cca_pkg::STATUS_IDX, 1'b1, 8'h0f);
    repeat (300) @(posedge clock);
    rchk(cca_pkg::STATUS_IDX, 8'h0a);
    xfer(cca_pkg::CONTROL_IDX, 1'b1, 8'h00);
    // reset after the counter is stopped brings outputs and registers back
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    chk({28'h000_0000, irq, pin_oe_n}, 32'h0000_0007);
    rchk(cca_pkg::MODE_IDX[1], 8'h00);
    rchk(cca_pkg::STATUS_IDX, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
